// ===== fdv_pkg.sv
package fdv_pkg;

  // Register indexes; byte address is four times the index
  localparam logic [7:0] FDV_CTRL_INDEX   = 8'h2E;
  localparam logic [7:0] FDV_VALUE_INDEX  = 8'h2F;
  localparam logic [7:0] FDV_STATUS_INDEX = 8'h30;
  localparam logic [7:0] FDV_CTRL_ADDR    = {FDV_CTRL_INDEX[5:0], 2'h0};
  localparam logic [7:0] FDV_VALUE_ADDR   = {FDV_VALUE_INDEX[5:0], 2'h0};
  localparam logic [7:0] FDV_STATUS_ADDR  = {FDV_STATUS_INDEX[5:0], 2'h0};

  // Control field positions
  localparam int unsigned FDV_SRC_SEL_BIT = 7;
  localparam int unsigned FDV_PRESC_HI_BIT = 6;
  localparam int unsigned FDV_PRESC_LO_BIT = 5;
  localparam int unsigned FDV_ENABLE_BIT  = 4;
  localparam logic [7:0]  FDV_CTRL_WMASK  = 8'hF0;

  // Status field positions
  localparam int unsigned FDV_STAT_TONE_BIT = 0;
  localparam int unsigned FDV_STAT_LS_BIT   = 1;
  localparam int unsigned FDV_STAT_HS_BIT   = 2;
  localparam int unsigned FDV_STAT_CNT_LSB  = 8;

  // Reset values
  localparam logic [7:0]  FDV_CTRL_RESET   = 8'h00;
  localparam logic [7:0]  FDV_VALUE_RESET  = 8'h00;
  localparam logic [7:0]  FDV_COUNT_RESET  = 8'h00;
  localparam logic [2:0]  FDV_PRESC_RESET  = 3'h0;
  localparam logic [31:0] FDV_RDATA_RESET  = 32'h0000_0000;

  // Source channels on the synchroniser
  localparam int unsigned FDV_SRC_CHANNELS = 2;
  localparam int unsigned FDV_CH_LOW       = 0;
  localparam int unsigned FDV_CH_HIGH      = 1;

  typedef enum logic {
    FDV_SRC_LOW,
    FDV_SRC_HIGH
  } fdv_src_t;

endpackage

// ===== fdv_prescaler.sv
`timescale 1ns/1ps
module fdv_prescaler
  import fdv_pkg::*;
(
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       reset,
  // Control
  input  wire logic       clear,
  input  wire logic [1:0] ratio,
  // Source edge in, tick out
  input  wire logic       src_edge,
  output logic            tick
);

  typedef struct packed {
    logic [2:0] count;
  } fdv_presc_state_t;

  fdv_presc_state_t st;
  fdv_presc_state_t next_st;
  logic [2:0]       mask;

  always_comb begin
    next_st = st;
    unique case (ratio)
      2'h0: mask = 3'h0;
      2'h1: mask = 3'h1;
      2'h2: mask = 3'h3;
      2'h3: mask = 3'h7;
    endcase
    // Tick on the edge that completes 1, 2, 4 or 8 source edges
    tick = src_edge && !clear && ((st.count & mask) == mask);
    if (clear) begin
      next_st.count = FDV_PRESC_RESET;
    end else if (src_edge) begin
      next_st.count = st.count + 3'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st.count <= FDV_PRESC_RESET;
    end else begin
      st <= next_st;
    end
  end

endmodule

// ===== fdv_freq_divider.sv
// How it works
// - Enable bit 4 drives tone, else low
// - Bits 6:5 prescale by 1, 2, 4, 8
// - Bit 7 picks fast quarter or slow clock
// - Control bits 3:0 read as zero
// - Eight-bit divide value feeds second counter stage
// - Divide value writes ignored while disabled
// - Disabled divider clears divide value register
// - Tone toggles every N+1 prescaler ticks
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
module fdv_freq_divider
  import fdv_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Source clocks from pins
  input  wire logic        low_speed_clk,
  input  wire logic        high_speed_quarter_clk,
  // Tone pin
  output logic             tone_output_pin
);

  typedef struct packed {
    logic [7:0]                  divider_control;
    logic [7:0]                  divider_value;
    logic [7:0]                  count;
    logic                        tone;
    logic [FDV_SRC_CHANNELS-1:0] sync1;
    logic [FDV_SRC_CHANNELS-1:0] sync2;
    logic [FDV_SRC_CHANNELS-1:0] sync3;
    logic [FDV_SRC_CHANNELS-1:0] level;
    logic [31:0]                 rdata;
    logic                        rerr;
  } fdv_core_state_t;

  fdv_core_state_t             st;
  fdv_core_state_t             next_st;
  logic [FDV_SRC_CHANNELS-1:0] src_pins;
  logic [FDV_SRC_CHANNELS-1:0] src_rise;
  logic                        divider_output_enable;
  logic [1:0]                  prescale_select;
  fdv_src_t                    divider_source_select;
  logic                        src_edge;
  logic                        presc_tick;
  logic                        setup_phase;
  logic                        access_write;

  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] reg_addr);
    reg_hit = (addr == reg_addr);
  endfunction

  assign src_pins[FDV_CH_LOW]  = low_speed_clk;
  assign src_pins[FDV_CH_HIGH] = high_speed_quarter_clk;

  assign divider_output_enable = st.divider_control[FDV_ENABLE_BIT];
  assign prescale_select       = st.divider_control[FDV_PRESC_HI_BIT:FDV_PRESC_LO_BIT];
  assign divider_source_select = st.divider_control[FDV_SRC_SEL_BIT] ? FDV_SRC_HIGH : FDV_SRC_LOW;

  // Rise counts once the second and third stages agree on high
  genvar g;
  generate
    for (g = 0; g < FDV_SRC_CHANNELS; g++) begin : g_rise
      assign src_rise[g] = (st.sync2[g] == st.sync3[g]) && st.sync3[g] && !st.level[g];
    end
  endgenerate

  assign src_edge = (divider_source_select == FDV_SRC_HIGH) ? src_rise[FDV_CH_HIGH]
                                                            : src_rise[FDV_CH_LOW];

  fdv_prescaler u_prescaler (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .clear    (!divider_output_enable),
    .ratio    (prescale_select),
    .src_edge (src_edge),
    .tick     (presc_tick)
  );

  // Read data is caught in the setup cycle so the access cycle answers at once
  assign setup_phase  = psel && !penable;
  assign access_write = psel && penable && pwrite;
  assign pready       = psel && penable;
  assign prdata       = st.rdata;
  assign pslverr      = pready && st.rerr;

  always_comb begin
    next_st = st;

    for (int i = 0; i < FDV_SRC_CHANNELS; i++) begin
      next_st.sync1[i] = src_pins[i];
      next_st.sync2[i] = st.sync1[i];
      next_st.sync3[i] = st.sync2[i];
      if (st.sync2[i] == st.sync3[i]) begin
        next_st.level[i] = st.sync3[i];
      end
    end

    if (setup_phase) begin
      next_st.rdata = FDV_RDATA_RESET;
      next_st.rerr  = 1'b0;
      if (reg_hit(paddr, FDV_CTRL_ADDR)) begin
        next_st.rdata[7:0] = st.divider_control & FDV_CTRL_WMASK;
      end else if (reg_hit(paddr, FDV_VALUE_ADDR)) begin
        next_st.rdata[7:0] = st.divider_value;
      end else if (reg_hit(paddr, FDV_STATUS_ADDR)) begin
        next_st.rdata[FDV_STAT_TONE_BIT]               = st.tone;
        next_st.rdata[FDV_STAT_LS_BIT]                 = st.level[FDV_CH_LOW];
        next_st.rdata[FDV_STAT_HS_BIT]                 = st.level[FDV_CH_HIGH];
        next_st.rdata[FDV_STAT_CNT_LSB +: 8]           = st.count;
      end else begin
        next_st.rerr = 1'b1;
      end
    end

    if (access_write) begin
      if (reg_hit(paddr, FDV_CTRL_ADDR)) begin
        next_st.divider_control = pwdata[7:0] & FDV_CTRL_WMASK;
      end else if (reg_hit(paddr, FDV_VALUE_ADDR) && divider_output_enable) begin
        next_st.divider_value = pwdata[7:0];
      end
    end

    if (!next_st.divider_control[FDV_ENABLE_BIT]) begin
      next_st.divider_value = FDV_VALUE_RESET;
    end

    if (!divider_output_enable) begin
      next_st.count = FDV_COUNT_RESET;
      next_st.tone  = 1'b0;
    end else if (presc_tick) begin
      // Compare with >= so a value lowered mid-period still ends the half period
      if (st.count >= st.divider_value) begin
        next_st.count = FDV_COUNT_RESET;
        next_st.tone  = !st.tone;
      end else begin
        next_st.count = st.count + 8'h01;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st.divider_control <= FDV_CTRL_RESET;
      st.divider_value   <= FDV_VALUE_RESET;
      st.count           <= FDV_COUNT_RESET;
      st.tone            <= 1'b0;
      st.sync1           <= '0;
      st.sync2           <= '0;
      st.sync3           <= '0;
      st.level           <= '0;
      st.rdata           <= FDV_RDATA_RESET;
      st.rerr            <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign tone_output_pin = st.tone;

endmodule

// ===== fdv_freq_divider_sva.sv
`timescale 1ns/1ps
module fdv_freq_divider_sva
  import fdv_pkg::*;
(
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        reset,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Pins
  input wire logic        low_speed_clk,
  input wire logic        high_speed_quarter_clk,
  input wire logic        tone_output_pin
);
  logic [3:0] ctl;
  logic [7:0] val;
  logic       wr;
  logic       rd;
  logic       map;
  assign wr  = psel && penable && pwrite;
  assign rd  = pready && !pwrite;
  assign map = paddr inside {FDV_CTRL_ADDR, FDV_VALUE_ADDR, FDV_STATUS_ADDR};
  // Shadow copy of the writable bits
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ctl <= 4'h0;
      val <= 8'h00;
    end else if (wr && paddr == FDV_CTRL_ADDR) begin
      ctl <= pwdata[7:4];
      if (!pwdata[4]) val <= 8'h00;
    end else if (wr && paddr == FDV_VALUE_ADDR && ctl[0]) begin
      val <= pwdata[7:0];
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  a_ready_zero_wait: assert property (pready == (psel && penable)) else $error("pready wrong");
  a_ctrl_readback: assert property (rd && paddr == FDV_CTRL_ADDR |-> prdata == {24'h0, ctl, 4'h0})
    else $error("control read wrong");
  a_value_readback: assert property (rd && paddr == FDV_VALUE_ADDR |-> prdata == {24'h0, val})
    else $error("value read wrong");
  a_err_decode: assert property (pready |-> pslverr == !map) else $error("pslverr wrong");
  a_err_data_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0) else $error("error data not zero");
  a_tone_low_off: assert property (!ctl[0] && !$past(ctl[0]) |-> !tone_output_pin)
    else $error("tone high while disabled");
  a_tone_start_low: assert property ($rose(ctl[0]) |-> !tone_output_pin [*3])
    else $error("tone not low at enable");
  a_err_needs_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
endmodule
bind fdv_freq_divider fdv_freq_divider_sva i_sva (.ref_clk(ref_clk), .reset(reset), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .low_speed_clk(low_speed_clk), .high_speed_quarter_clk(high_speed_quarter_clk),
  .tone_output_pin(tone_output_pin));

// ===== fdv_freq_divider_tb.sv
`timescale 1ns/1ps
module fdv_freq_divider_tb
  import fdv_pkg::*;
;
  logic        ref_clk, reset, psel, penable, pwrite, er, low_speed_clk, high_speed_quarter_clk;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, tone_output_pin;
  int          failures, checks_done, cyc, lc, hc;
  fdv_freq_divider i_fdv_freq_divider (.ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .low_speed_clk(low_speed_clk), .high_speed_quarter_clk(high_speed_quarter_clk),
    .tone_output_pin(tone_output_pin));
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // Sources locked to ref_clk so half periods come out exact
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    hc <= (hc == 7) ? 0 : hc + 1;
    lc <= (lc == 11) ? 0 : lc + 1;
    high_speed_quarter_clk <= hc < 4;
    low_speed_clk <= lc < 6;
    if (cyc == 40000) begin
      failures++;
      end_sim;
    end
  end
  task end_sim;
    if (failures == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rchk(input string n, input logic [7:0] a, input logic [31:0] e, input logic ee);
    apb(1'b0, a, 32'h0);
    chk(n, e, rd);
    chk("pslverr", {31'h0, ee}, {31'h0, er});
  endtask
  task t_regs;
    rchk("ctrl", FDV_CTRL_ADDR, 32'h0, 1'b0);
    rchk("value", FDV_VALUE_ADDR, 32'h0, 1'b0);
    apb(1'b1, FDV_VALUE_ADDR, 32'h55);
    rchk("value", FDV_VALUE_ADDR, 32'h0, 1'b0);
    apb(1'b1, FDV_CTRL_ADDR, 32'hFF);
    rchk("ctrl", FDV_CTRL_ADDR, 32'hF0, 1'b0);
    apb(1'b1, FDV_VALUE_ADDR, 32'hA5);
    rchk("value", FDV_VALUE_ADDR, 32'hA5, 1'b0);
    apb(1'b1, FDV_CTRL_ADDR, 32'h0F);
    rchk("value", FDV_VALUE_ADDR, 32'h0, 1'b0);
    // Source level bits follow the free-running pins, so only tone and count are judged
    apb(1'b0, FDV_STATUS_ADDR, 32'h0);
    chk("status", 32'h0, rd & 32'h0000_FF01);
    chk("pslverr", 32'h0, {31'h0, er});
    rchk("hole", 8'h04, 32'h0, 1'b1);
  endtask
  task t_freq(input logic [7:0] c, input logic [7:0] v, input logic [31:0] h);
    time t0;
    apb(1'b1, FDV_CTRL_ADDR, {24'h0, c});
    apb(1'b1, FDV_VALUE_ADDR, {24'h0, v});
    // Skip the half period that straddles the value write
    @(negedge tone_output_pin);
    @(posedge tone_output_pin);
    t0 = $time;
    @(negedge tone_output_pin);
    chk("half_period", h, 32'(($time - t0) / 100));
    apb(1'b1, FDV_CTRL_ADDR, 32'h0);
    repeat (2) @(posedge ref_clk);
    chk("tone", 32'h0, {31'h0, tone_output_pin});
  endtask
  initial begin
    {reset, psel, penable, pwrite, low_speed_clk, high_speed_quarter_clk} = 6'h20;
    paddr = 8'h00;
    pwdata = 32'h0;
    {failures, checks_done, cyc, lc, hc} = '0;
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    t_regs;
    for (int r = 0; r < 4; r++) t_freq(8'(8'h90 | (r << 5)), 8'h02, 32'(24 << r));
    t_freq(8'h30, 8'h04, 32'd120);
    t_freq(8'h90, 8'h00, 32'd8);
    t_freq(8'h90, 8'hFF, 32'd2048);
    end_sim;
  end
endmodule
